/* File: src/dbpm_defines.svh */
// Constants for the dual byte port and bus multiplexer
`ifndef DBPM_DEFINES_SVH
`define DBPM_DEFINES_SVH
// Register addresses on the plain register port
`define DBPM_A_FP_PINS 4'h0
`define DBPM_A_FP_LATCH 4'h1
`define DBPM_A_FP_DIR 4'h2
`define DBPM_A_SP_PINS 4'h3
`define DBPM_A_SP_LATCH 4'h4
`define DBPM_A_SP_DIR 4'h5
`define DBPM_A_SLV_CTRL 4'h6
`define DBPM_A_MEM_CTRL 4'h7
// Reset values
`define DBPM_DIR_RST 8'hFF
`define DBPM_LAT_RST 8'h00
`define DBPM_CTL_RST 8'h00
`define DBPM_PAD_RST 16'h0000
// Field positions and implemented-bit masks
`define DBPM_BIT_BUSDIS 7
`define DBPM_BIT_SLVEN 4
`define DBPM_MEM_MASK 8'hB3
`define DBPM_SLV_MASK 8'h10
// Program memory mode codes
`define DBPM_MODE_MCU 2'h0
`define DBPM_MODE_MPU 2'h1
`define DBPM_MODE_EXT 2'h2
// Second-port pin roles and masks
`define DBPM_PIN_RD 8
`define DBPM_PIN_WR 9
`define DBPM_PIN_CS 10
`define DBPM_PIN_CH2 7
`define DBPM_CTRL_MASK 8'h07
`define DBPM_CH2_MASK 8'h80
`define DBPM_ZERO8 8'h00
`define DBPM_ONES8 8'hFF
`endif

/* File: src/dbpm_pkg.sv */
// Types shared by the dual byte port and bus multiplexer
package dbpm_pkg;
  `include "dbpm_defines.svh"

  // Slave transfer state, Gray along idle-read and idle-write
  typedef enum logic [1:0] {
    DBPM_IDLE = 2'h0,
    DBPM_HREAD = 2'h1,
    DBPM_HWRITE = 2'h2
  } dbpm_slv_t;

  // Pad drive of one port
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } dbpm_pad_t;

  // Per-bit takeover of a port by a peripheral function
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] out;
    logic [7:0] oe;
  } dbpm_ovr_t;

  // Three-stage pin synchroniser with agreement filter
  typedef struct packed {
    logic [15:0] s1;
    logic [15:0] s2;
    logic [15:0] s3;
    logic [15:0] stable;
  } dbpm_sync_t;

  // State of the main module apart from the reset synchroniser
  typedef struct packed {
    logic [7:0] fpLatch;
    logic [7:0] fpDir;
    logic [7:0] spLatch;
    logic [7:0] spDir;
    logic [7:0] slvCtrl;
    logic [7:0] memCtrl;
    logic [7:0] rdData;
    logic [7:0] slaveIn;
    dbpm_slv_t slv;
    logic wrPulse;
    logic rdPulse;
  } dbpm_state_t;
endpackage

/* File: src/dbpm_sync.sv */
// Three-flop pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module dbpm_sync
  import dbpm_pkg::*;
(
  // Clock and synchronised reset
  input wire logic clock,
  input wire logic rstSync_n,
  // Raw pins and filtered levels
  input wire logic [15:0] raw,
  output logic [15:0] stable
);
  dbpm_sync_t st_r;
  dbpm_sync_t st_nxt;

  // Stage one feeds only stage two, never the filter
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = raw;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.stable = (st_r.s2 & ~(st_r.s2 ^ st_r.s3)) | (st_r.stable & (st_r.s2 ^ st_r.s3));
  end

  // State register
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= '1; // Strobes idle high, so no false host strobe after reset
    end else begin
      st_r <= st_nxt;
    end
  end

  assign stable = st_r.stable;
endmodule
`default_nettype wire

/* File: src/dbpm_pin_mux.sv */
// Pad driver of one 8-bit port: bus, peripheral takeover or latch and direction
`timescale 1ns/100ps
`default_nettype none
`include "dbpm_defines.svh"
module dbpm_pin_mux
  import dbpm_pkg::*;
(
  // Clock and synchronised reset
  input wire logic clock,
  input wire logic rstSync_n,
  // Port registers
  input wire logic [7:0] latch,
  input wire logic [7:0] dir,
  // System bus ownership
  input wire logic busOwn,
  input wire logic [7:0] busOut,
  input wire logic busOe,
  // Peripheral takeover
  input wire dbpm_ovr_t ovr,
  // Pads
  output logic [7:0] padOut,
  output logic [7:0] padOe
);
  dbpm_pad_t st_r;
  dbpm_pad_t st_nxt;

  // Bus wins over everything; else direction 1 means input
  always_comb begin
    st_nxt = st_r;
    if (busOwn) begin
      st_nxt.out = busOut;
      st_nxt.oe = {8{busOe}};
    end else begin
      st_nxt.out = (ovr.mask & ovr.out) | (~ovr.mask & latch);
      st_nxt.oe = (ovr.mask & ovr.oe) | (~ovr.mask & ~dir);
    end
  end

  // Registered pads so nothing glitches off decode logic; reset leaves all undriven
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r <= `DBPM_PAD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign padOut = st_r.out;
  assign padOe = st_r.oe;
endmodule
`default_nettype wire

/* File: src/dbpm_port_mux.sv */
// Dual byte general-purpose port shared with the multiplexed system bus and slave port
//
// Behaviour
// - First port direction 1 makes pin input
// - First port direction 0 drives latch value
// - First port latch register reads latched value
// - Reset sets first port direction all ones
// - First port is GPIO only when bus disabled
// - Active bus puts low byte on first port
// - Slave mode makes first port host data port
// - Second port direction 1 makes pin input
// - Second port direction 0 drives latch value
// - Second port latch register reads latched value
// - Large variant second port GPIO needs bus disabled
// - Large variant processor modes put high byte on second
// - Slave mode turns pins 2..0 into controls
// - Pin 7 carries channel 2 when selected
// - Large extended mode starts on system bus
// - Select low means chosen, high means not
//
// Our own choices: the placing of the registers and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "dbpm_defines.svh"
module dbpm_port_mux
  import dbpm_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // Device configuration levels
  input wire logic [1:0] memMode,
  input wire logic largeVariant,
  input wire logic channel2PinSelect,
  // External bus engine side
  input wire logic [15:0] extBusOut,
  input wire logic extBusOe,
  output logic [15:0] extBusIn,
  output logic extBusActive,
  // Capture/compare channel 2 side
  input wire logic ch2Out,
  input wire logic ch2Oe,
  output logic ch2Routed,
  // Slave port events
  output logic [7:0] slaveData,
  output logic slaveWrPulse,
  output logic slaveRdPulse,
  // First port pads
  input wire logic [7:0] fpIn,
  output logic [7:0] fpOut,
  output logic [7:0] fpOe,
  // Second port pads
  input wire logic [7:0] spIn,
  output logic [7:0] spOut,
  output logic [7:0] spOe
);
  logic [1:0] rstPipe_r;
  logic rstSync_n;
  dbpm_state_t st_r;
  dbpm_state_t st_nxt;
  logic [15:0] pinStable;
  logic busActive;
  logic fpBus;
  logic spBus;
  logic slaveActive;
  logic ch2Take;
  logic hostSel;
  logic hostRd;
  logic hostWr;
  dbpm_ovr_t fpOvr;
  dbpm_ovr_t spOvr;

  // Field write with unimplemented bits held at zero
  function automatic logic [7:0] maskedWrite(input logic [7:0] data, input logic [7:0] mask);
    maskedWrite = data & mask;
  endfunction

  // Address match against a strobe
  function automatic logic hit(input logic stb, input logic [3:0] addr, input logic [3:0] want);
    hit = stb && (addr == want);
  endfunction

  // Reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_r <= 2'h0;
    end else begin
      rstPipe_r <= {rstPipe_r[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_r[1];

  // Both ports come from pins, so both pass the three-flop filter
  dbpm_sync u_sync (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .raw({spIn, fpIn}),
    .stable(pinStable)
  );

  // Ownership decode; bus needs a processor mode and bus-disable clear
  assign busActive = (memMode != `DBPM_MODE_MCU) && !st_r.memCtrl[`DBPM_BIT_BUSDIS];
  assign fpBus = busActive;
  assign spBus = busActive && largeVariant;
  assign slaveActive = st_r.slvCtrl[`DBPM_BIT_SLVEN] && (memMode == `DBPM_MODE_MCU);
  assign ch2Take = (memMode == `DBPM_MODE_MCU) && !channel2PinSelect;

  // Host strobes, active low; select high blocks everything
  assign hostSel = !pinStable[`DBPM_PIN_CS];
  assign hostRd = hostSel && !pinStable[`DBPM_PIN_RD];
  assign hostWr = hostSel && !pinStable[`DBPM_PIN_WR] && pinStable[`DBPM_PIN_RD];

  // First port: whole byte goes to the host only during a host read
  always_comb begin
    fpOvr.mask = slaveActive ? `DBPM_ONES8 : `DBPM_ZERO8;
    fpOvr.out = st_r.fpLatch;
    fpOvr.oe = (st_r.slv == DBPM_HREAD) ? `DBPM_ONES8 : `DBPM_ZERO8;
  end

  // Second port: controls forced to input even if software forgot the direction bits
  always_comb begin
    spOvr.mask = (slaveActive ? `DBPM_CTRL_MASK : `DBPM_ZERO8) |
                 (ch2Take ? `DBPM_CH2_MASK : `DBPM_ZERO8);
    spOvr.out = ch2Out ? `DBPM_CH2_MASK : `DBPM_ZERO8;
    spOvr.oe = ch2Oe ? `DBPM_CH2_MASK : `DBPM_ZERO8;
  end

  // Next state: register writes, register reads and slave sequencing
  always_comb begin
    st_nxt = st_r;
    st_nxt.wrPulse = 1'b0;
    st_nxt.rdPulse = 1'b0;
    st_nxt.rdData = `DBPM_ZERO8;
    // Pins and latch addresses both land in the latch
    if (hit(regWrStb, regAddr, `DBPM_A_FP_PINS) || hit(regWrStb, regAddr, `DBPM_A_FP_LATCH)) begin
      st_nxt.fpLatch = regWrData;
    end
    if (hit(regWrStb, regAddr, `DBPM_A_SP_PINS) || hit(regWrStb, regAddr, `DBPM_A_SP_LATCH)) begin
      st_nxt.spLatch = regWrData;
    end
    if (hit(regWrStb, regAddr, `DBPM_A_FP_DIR)) begin
      st_nxt.fpDir = regWrData;
    end
    if (hit(regWrStb, regAddr, `DBPM_A_SP_DIR)) begin
      st_nxt.spDir = regWrData;
    end
    if (hit(regWrStb, regAddr, `DBPM_A_SLV_CTRL)) begin
      st_nxt.slvCtrl = maskedWrite(regWrData, `DBPM_SLV_MASK);
    end
    if (hit(regWrStb, regAddr, `DBPM_A_MEM_CTRL)) begin
      st_nxt.memCtrl = maskedWrite(regWrData, `DBPM_MEM_MASK);
    end
    // Read data stands only in the cycle after the strobe; unmapped reads zero
    if (regRdStb) begin
      case (regAddr)
        `DBPM_A_FP_PINS: st_nxt.rdData = pinStable[7:0];
        `DBPM_A_FP_LATCH: st_nxt.rdData = st_r.fpLatch;
        `DBPM_A_FP_DIR: st_nxt.rdData = st_r.fpDir;
        `DBPM_A_SP_PINS: st_nxt.rdData = pinStable[15:8];
        `DBPM_A_SP_LATCH: st_nxt.rdData = st_r.spLatch;
        `DBPM_A_SP_DIR: st_nxt.rdData = st_r.spDir;
        `DBPM_A_SLV_CTRL: st_nxt.rdData = st_r.slvCtrl;
        `DBPM_A_MEM_CTRL: st_nxt.rdData = st_r.memCtrl;
        default: st_nxt.rdData = `DBPM_ZERO8;
      endcase
    end
    // Host transfer sequencer; leaving slave mode aborts without a pulse
    if (!slaveActive) begin
      st_nxt.slv = DBPM_IDLE;
    end else begin
      case (st_r.slv)
        DBPM_IDLE: begin
          if (hostRd) begin
            st_nxt.slv = DBPM_HREAD;
          end else if (hostWr) begin
            st_nxt.slv = DBPM_HWRITE;
          end
        end
        DBPM_HREAD: begin
          if (!hostRd) begin
            st_nxt.slv = DBPM_IDLE;
            st_nxt.rdPulse = 1'b1;
          end
        end
        DBPM_HWRITE: begin
          // Keep sampling while the strobe is low; last byte before release wins
          if (hostWr) begin
            st_nxt.slaveIn = pinStable[7:0];
          end else begin
            st_nxt.slv = DBPM_IDLE;
            st_nxt.wrPulse = 1'b1;
          end
        end
        default: st_nxt.slv = DBPM_IDLE;
      endcase
    end
  end

  // State register; control state defined at reset
  always_ff @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      st_r.fpLatch <= `DBPM_LAT_RST;
      st_r.fpDir <= `DBPM_DIR_RST;
      st_r.spLatch <= `DBPM_LAT_RST;
      st_r.spDir <= `DBPM_DIR_RST;
      st_r.slvCtrl <= `DBPM_CTL_RST;
      st_r.memCtrl <= `DBPM_CTL_RST;
      st_r.rdData <= `DBPM_ZERO8;
      st_r.slaveIn <= `DBPM_ZERO8;
      st_r.slv <= DBPM_IDLE;
      st_r.wrPulse <= 1'b0;
      st_r.rdPulse <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Low byte pads
  dbpm_pin_mux u_fp (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .latch(st_r.fpLatch),
    .dir(st_r.fpDir),
    .busOwn(fpBus),
    .busOut(extBusOut[7:0]),
    .busOe(extBusOe),
    .ovr(fpOvr),
    .padOut(fpOut),
    .padOe(fpOe)
  );

  // High byte pads
  dbpm_pin_mux u_sp (
    .clock(clock),
    .rstSync_n(rstSync_n),
    .latch(st_r.spLatch),
    .dir(st_r.spDir),
    .busOwn(spBus),
    .busOut(extBusOut[15:8]),
    .busOe(extBusOe),
    .ovr(spOvr),
    .padOut(spOut),
    .padOe(spOe)
  );

  // Outputs
  assign regRdData = st_r.rdData;
  assign extBusIn = pinStable;
  assign extBusActive = busActive;
  assign ch2Routed = ch2Take && !spBus;
  assign slaveData = st_r.slaveIn;
  assign slaveWrPulse = st_r.wrPulse;
  assign slaveRdPulse = st_r.rdPulse;

  // Checks on the registered pads and registers
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstSync_n);

  logic fpGpio;
  logic spGpio;
  assign fpGpio = !fpBus && !slaveActive;
  assign spGpio = !spBus;

  sequence hostWriteEnd;
    (st_r.slv == DBPM_HWRITE) && slaveActive ##1 (st_r.slv == DBPM_IDLE);
  endsequence

  sequence hostReadHeld;
    $past(slaveActive) && $past(st_r.slv == DBPM_HREAD);
  endsequence

  fp_input_dir_a: assert property (
    $past(fpGpio) |-> ((fpOe & $past(st_r.fpDir)) == `DBPM_ZERO8))
    else $error("first port pin driven while direction is input");

  fp_output_dir_a: assert property (
    $past(fpGpio) |-> ((fpOe | $past(st_r.fpDir)) == `DBPM_ONES8) &&
      ((fpOut & ~$past(st_r.fpDir)) == ($past(st_r.fpLatch) & ~$past(st_r.fpDir))))
    else $error("first port output does not follow latch");

  fp_latch_read_a: assert property (
    hit(regRdStb, regAddr, `DBPM_A_FP_LATCH) |=> (regRdData == $past(st_r.fpLatch)))
    else $error("first port latch read wrong");

  reset_dir_a: assert property (
    $rose(rstSync_n) |-> (st_r.fpDir == `DBPM_DIR_RST) && (st_r.spDir == `DBPM_DIR_RST)
      && (fpOe == `DBPM_ZERO8))
    else $error("direction not all input after reset");

  fp_bus_own_a: assert property (
    $past(rstSync_n) && $past(fpBus) |->
      (fpOut == $past(extBusOut[7:0])) && (fpOe == {8{$past(extBusOe)}}))
    else $error("first port not carrying bus low byte");

  host_read_drive_a: assert property (
    hostReadHeld |-> (fpOe == `DBPM_ONES8) && (fpOut == $past(st_r.fpLatch)))
    else $error("host read not driving latch byte");

  host_write_pulse_a: assert property (
    hostWriteEnd |-> slaveWrPulse ##1 !slaveWrPulse)
    else $error("host write end not a single pulse");

  sp_dir_follow_a: assert property (
    $past(spGpio) && !$past(slaveActive) && !$past(ch2Take) |->
      (spOe == ~$past(st_r.spDir)) && ((spOut & spOe) == ($past(st_r.spLatch) & spOe)))
    else $error("second port pad not following direction and latch");

  sp_latch_rw_a: assert property (
    hit(regWrStb, regAddr, `DBPM_A_SP_PINS) ##1 hit(regRdStb, regAddr, `DBPM_A_SP_LATCH)
      |=> (regRdData == $past(regWrData, 2)))
    else $error("second port latch not updated by pins write");

  sp_bus_own_a: assert property (
    $past(rstSync_n) && $past(spBus) |->
      (spOut == $past(extBusOut[15:8])) && (spOe == {8{$past(extBusOe)}}))
    else $error("second port not carrying bus high byte");

  ctrl_inputs_a: assert property (
    $past(slaveActive) |-> ((spOe & `DBPM_CTRL_MASK) == `DBPM_ZERO8))
    else $error("slave control pin driven");

  ch2_route_a: assert property (
    $past(rstSync_n) && $past(ch2Take) && $past(spGpio) |-> (spOe[`DBPM_PIN_CH2] == $past(ch2Oe)))
    else $error("channel 2 pin not routed");

  ext_reset_bus_a: assert property (
    $rose(rstSync_n) && largeVariant && (memMode == `DBPM_MODE_EXT) |-> spBus)
    else $error("large extended mode not on bus after reset");

  deselect_idle_a: assert property (
    (st_r.slv == DBPM_IDLE) && pinStable[`DBPM_PIN_CS] |=> (st_r.slv == DBPM_IDLE))
    else $error("transfer started while not selected");

  pins_write_latch_a: assert property (
    hit(regWrStb, regAddr, `DBPM_A_FP_PINS) |=> (st_r.fpLatch == $past(regWrData)))
    else $error("pins write did not reach latch");
endmodule
`default_nettype wire

/* File: bench/dbpm_host_model.sv */
// Host and board model on the pin side of both ports
`timescale 1ns/100ps
`default_nettype none
module dbpm_host_model (
  // Clock
  input wire logic clock,
  // Pad drive from the block
  input wire logic [7:0] fpOut,
  input wire logic [7:0] fpOe,
  input wire logic [7:0] spOut,
  input wire logic [7:0] spOe,
  // Board drive outside host transfers
  input wire logic [7:0] extFp,
  input wire logic extFpEn,
  input wire logic [7:0] extSp,
  // Resolved pin levels
  output logic [7:0] fpIn,
  output logic [7:0] spIn
);
  logic [7:0] dat = 8'h00;
  logic datEn = 1'b0;
  logic hostOn = 1'b0;
  logic [2:0] ctl = 3'h7; // {select_n, write_n, read_n}
  logic [7:0] flt = 8'h00;

  // Undriven lines wander so a stale value never passes for a driven one
  always @(posedge clock) flt <= flt + 8'h5B;

  // Wire resolution: block drive, then host, then board
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      fpIn[i] = fpOe[i] ? fpOut[i] : datEn ? dat[i] : extFpEn ? extFp[i] : flt[i];
      spIn[i] = spOe[i] ? spOut[i] : (hostOn && i < 3) ? ctl[i] : extSp[i];
    end
  end

  // One host strobe; data held past the release, pins sampled before it
  task automatic hostCycle(input logic [2:0] c, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    hostOn <= 1'b1;
    ctl <= c;
    dat <= d;
    datEn <= c[0];
    repeat (9) @(posedge clock);
    q = fpIn;
    ctl <= 3'h7;
    repeat (6) @(posedge clock);
    datEn <= 1'b0;
    hostOn <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/dbpm_port_mux_tb.sv */
// Self-checking bench for the dual byte port and bus multiplexer
`timescale 1ns/100ps
`default_nettype none
`include "dbpm_defines.svh"
module dbpm_port_mux_tb
  import dbpm_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic [7:0] regRdData;
  logic [1:0] memMode = 2'h0;
  logic largeVariant = 1'b0;
  logic ch2Sel = 1'b1;
  logic [15:0] extBusOut = 16'h0000;
  logic extBusOe = 1'b0;
  logic [15:0] extBusIn;
  logic extBusActive;
  logic ch2Out = 1'b0;
  logic ch2Oe = 1'b0;
  logic ch2Routed;
  logic [7:0] slaveData;
  logic slaveWrPulse;
  logic slaveRdPulse;
  logic [7:0] fpIn, fpOut, fpOe, spIn, spOut, spOe;
  logic [7:0] extFp = 8'h00;
  logic extFpEn = 1'b0;
  logic [7:0] extSp = 8'hFF;
  logic [3:0] aP, aL, aD;
  logic [7:0] q;
  int error_cnt = 0;
  int tests_run = 0;
  int wrCnt = 0;
  int rdCnt = 0;

  // 10 MHz clock
  always #50 clock = ~clock;

  dbpm_port_mux uut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .memMode(memMode), .largeVariant(largeVariant),
    .channel2PinSelect(ch2Sel), .extBusOut(extBusOut), .extBusOe(extBusOe),
    .extBusIn(extBusIn), .extBusActive(extBusActive), .ch2Out(ch2Out),
    .ch2Oe(ch2Oe), .ch2Routed(ch2Routed), .slaveData(slaveData),
    .slaveWrPulse(slaveWrPulse), .slaveRdPulse(slaveRdPulse), .fpIn(fpIn),
    .fpOut(fpOut), .fpOe(fpOe), .spIn(spIn), .spOut(spOut), .spOe(spOe));

  dbpm_host_model host (.clock(clock), .fpOut(fpOut), .fpOe(fpOe), .spOut(spOut),
    .spOe(spOe), .extFp(extFp), .extFpEn(extFpEn), .extSp(extSp), .fpIn(fpIn),
    .spIn(spIn));

  // Count one-cycle slave pulses
  always @(posedge clock) begin
    if (slaveWrPulse === 1'b1) wrCnt <= wrCnt + 1;
    if (slaveRdPulse === 1'b1) rdCnt <= rdCnt + 1;
  end

  task automatic chkB(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic chkF(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrStb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    @(posedge clock);
    regRdStb <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 chkB("regRdData", e, regRdData);
  endtask

  // Write then read with no idle cycle between the strobes
  task automatic wrRd(input logic [3:0] a, input logic [7:0] d, input logic [3:0] b,
    input logic [7:0] e);
    @(posedge clock);
    regWrStb <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWrStb <= 1'b0;
    regRdStb <= 1'b1;
    regAddr <= b;
    @(posedge clock);
    regRdStb <= 1'b0;
    #1 chkB("regRdData", e, regRdData);
  endtask

  // Sample mid-cycle, clear of edge updates
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    @(negedge clock);
  endtask

  task automatic doReset();
    rst_n <= 1'b0;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask

  task automatic close_out();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #5000000;
    error_cnt++;
    close_out();
  end

  initial begin
    doReset();
    // Reset state and unmapped space
    rdc(`DBPM_A_FP_DIR, 8'hFF);
    rdc(`DBPM_A_SP_DIR, 8'hFF);
    rdc(`DBPM_A_MEM_CTRL, 8'h00);
    wr(4'h9, 8'hFF);
    rdc(4'h9, 8'h00);
    chkB("fpOe", 8'h00, fpOe);
    chkB("spOe", 8'h00, spOe);
    // Both ports as I/O, upper half out, lower half in
    @(posedge clock);
    extFpEn <= 1'b1;
    extFp <= 8'h3C;
    extSp <= 8'h3C;
    for (int p = 0; p < 2; p++) begin
      aP = p ? `DBPM_A_SP_PINS : `DBPM_A_FP_PINS;
      aL = p ? `DBPM_A_SP_LATCH : `DBPM_A_FP_LATCH;
      aD = p ? `DBPM_A_SP_DIR : `DBPM_A_FP_DIR;
      wr(aL, 8'hA5);
      wr(aD, 8'h0F);
      tick(8);
      chkB("portOe", 8'hF0, p ? spOe : fpOe);
      chkB("portOut", 8'hA0, p ? (spOut & spOe) : (fpOut & fpOe));
      rdc(aP, 8'hAC);
      rdc(aL, 8'hA5);
      wrRd(aP, 8'h5A, aL, 8'h5A);
      wr(aD, 8'hFF);
      tick(2);
      chkB("portOe", 8'h00, p ? spOe : fpOe);
    end
    // Channel 2 borrows second port pin 7 in controller mode
    @(posedge clock);
    extSp <= 8'hFF;
    ch2Sel <= 1'b0;
    ch2Oe <= 1'b1;
    ch2Out <= 1'b1;
    tick(3);
    chkF("ch2Routed", 1'b1, ch2Routed);
    chkF("spOe7", 1'b1, spOe[7]);
    chkF("spOut7", 1'b1, spOut[7]);
    @(posedge clock);
    ch2Out <= 1'b0;
    tick(3);
    chkF("spOut7", 1'b0, spOut[7]);
    @(posedge clock);
    ch2Sel <= 1'b1;
    tick(3);
    chkF("ch2Routed", 1'b0, ch2Routed);
    // Slave mode: control pins forced in, then host write, read, unselected strobe
    // Latch holds the control pins idle high while software still drives them
    wr(`DBPM_A_SP_LATCH, 8'h07);
    wr(`DBPM_A_SP_DIR, 8'hF8);
    wr(`DBPM_A_SLV_CTRL, 8'hFF);
    rdc(`DBPM_A_SLV_CTRL, 8'h10);
    tick(2);
    chkB("spOeCtl", 8'h00, spOe & 8'h07);
    wr(`DBPM_A_SP_DIR, 8'hFF);
    wr(`DBPM_A_FP_LATCH, 8'h69);
    extFpEn <= 1'b0;
    host.hostCycle(3'h1, 8'h96, q);
    for (int i = 0; i < 20 && wrCnt == 0; i++) @(posedge clock);
    chkB("wrCnt", 8'h01, wrCnt[7:0]);
    chkB("slaveData", 8'h96, slaveData);
    host.hostCycle(3'h2, 8'h00, q);
    chkB("hostRead", 8'h69, q);
    for (int i = 0; i < 20 && rdCnt == 0; i++) @(posedge clock);
    chkB("rdCnt", 8'h01, rdCnt[7:0]);
    host.hostCycle(3'h5, 8'h33, q);
    tick(10);
    chkB("wrCnt", 8'h01, wrCnt[7:0]);
    chkB("slaveData", 8'h96, slaveData);
    // Large part in extended mode comes out of reset on the bus
    @(posedge clock);
    memMode <= 2'h2;
    largeVariant <= 1'b1;
    extBusOut <= 16'hC33C;
    extBusOe <= 1'b1;
    doReset();
    tick(1);
    chkF("extBusActive", 1'b1, extBusActive);
    chkB("fpOut", 8'h3C, fpOut);
    chkB("fpOe", 8'hFF, fpOe);
    chkB("spOut", 8'hC3, spOut);
    chkB("spOe", 8'hFF, spOe);
    tick(4);
    chkB("extBusInLo", 8'h3C, extBusIn[7:0]);
    chkB("extBusInHi", 8'hC3, extBusIn[15:8]);
    wr(`DBPM_A_MEM_CTRL, 8'hFF);
    rdc(`DBPM_A_MEM_CTRL, 8'hB3);
    tick(2);
    chkF("extBusActive", 1'b0, extBusActive);
    chkB("fpOe", 8'h00, fpOe);
    chkB("spOe", 8'h00, spOe);
    // Processor mode on the small part leaves the second port as I/O
    @(posedge clock);
    memMode <= 2'h1;
    largeVariant <= 1'b0;
    wr(`DBPM_A_MEM_CTRL, 8'h00);
    tick(2);
    chkB("fpOe", 8'hFF, fpOe);
    chkB("spOe", 8'h00, spOe);
    close_out();
  end
endmodule
`default_nettype wire
